// ### pkg/mcs_pkg.sv
// constants of the main clock select and oscillator settle block.
// assumes byte-wide register access from the cpu memory instructions.
`default_nettype none
package mcs_pkg;
	// register offsets
	localparam logic [15:0] MCS_OFF_RING_CTRL = 16'hffa0;
	localparam logic [15:0] MCS_OFF_CLK_SEL = 16'hffa1;
	localparam logic [15:0] MCS_OFF_MAIN_STOP = 16'hffa2;
	localparam logic [15:0] MCS_OFF_SETTLE_STAT = 16'hffa3;
	localparam logic [15:0] MCS_OFF_SETTLE_WAIT = 16'hffa4;

	// field positions
	localparam int MCS_BIT_RING_STOP = 0;
	localparam int MCS_BIT_CLK_SEL = 0;
	localparam int MCS_BIT_CLK_STATUS = 1;
	localparam int MCS_BIT_X1_STOP = 7;
	localparam int MCS_WAIT_CODE_W = 3;
	localparam int MCS_STAGES = 5;

	// reset values
	localparam logic [7:0] MCS_RST_RING_CTRL = 8'h00;
	localparam logic [7:0] MCS_RST_CLK_SEL = 8'h00;
	localparam logic [7:0] MCS_RST_MAIN_STOP = 8'h00;
	localparam logic [2:0] MCS_RST_SETTLE_WAIT = 3'h5;

	// timing counts, in oscillator cycles
	localparam logic [4:0] MCS_START_RING_CYCLES = 5'h11;
	localparam int MCS_SETTLE_CNT_W = 17;
	// settle thresholds as powers of two: 11, 13, 14, 15, 16
	localparam logic [4:0] MCS_SETTLE_EXP [MCS_STAGES] = '{5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h10};

	typedef enum logic [1:0] {
		MCS_SRC_RING = 2'b00,
		MCS_SRC_TO_X1 = 2'b01,
		MCS_SRC_X1 = 2'b10,
		MCS_SRC_TO_RING = 2'b11
	} mcs_src_state_type;
endpackage
`default_nettype wire

// ### pkg/mcs_settle_if.sv
// carrier between the clock control core and the settle counter.
// assumes both ends run on the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface mcs_settle_if;
	logic x1_edge;
	logic clear;
	logic limit;
	logic [mcs_pkg::MCS_WAIT_CODE_W-1:0] wait_code;
	logic [mcs_pkg::MCS_STAGES-1:0] status;
	logic wait_done;

	modport ctl (output x1_edge, output clear, output limit, output wait_code,
		input status, input wait_done);
	modport cnt (input x1_edge, input clear, input limit, input wait_code,
		output status, output wait_done);
endinterface
`default_nettype wire

// ### logic/mcs_settle_counter.sv
// x1 oscillation settle counter and its thermometer status.
// assumes x1_edge is a one-cycle pulse per x1 cycle from the core.
`timescale 1ns/1ps
`default_nettype none
module mcs_settle_counter (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// link to core
	mcs_settle_if.cnt sif
);
	localparam int W = mcs_pkg::MCS_SETTLE_CNT_W;
	localparam int N = mcs_pkg::MCS_STAGES;

	logic [W-1:0] cnt_q;
	logic [N-1:0] reach;
	logic [N-1:0] allow;
	logic [2:0] stages;
	logic at_limit;

	// prohibited codes behave as the longest wait
	always_comb begin
		if (sif.wait_code == 3'h0 || sif.wait_code > 3'h5) begin
			stages = 3'h5;
		end else begin
			stages = sif.wait_code;
		end
	end

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_stage
			assign reach[i] = cnt_q[mcs_pkg::MCS_SETTLE_EXP[i]] |
				(cnt_q >> mcs_pkg::MCS_SETTLE_EXP[i] != '0);
			assign allow[i] = !sif.limit || (3'(i) < stages); // see [RULE_15]
			// stage1 sits in bit 4, stage5 in bit 0
			assign sif.status[N-1-i] = reach[i] && allow[i]; // see [RULE_14]
		end
	endgenerate

	assign at_limit = reach[stages-3'h1];
	assign sif.wait_done = sif.limit && at_limit;

	// counts x1 edges only, so time before oscillation starts is excluded
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0; // see [RULE_13]
		end else if (sif.clear) begin
			cnt_q <= '0; // see [RULE_13]
		end else if (sif.x1_edge && !reach[N-1] && !(sif.limit && at_limit)) begin
			cnt_q <= cnt_q + W'(1); // see [RULE_18]
		end
	end
endmodule // mcs_settle_counter
`default_nettype wire

// ### logic/mcs_clock_ctrl.sv
// main clock select, oscillator stop control and settle tracking.
// assumes oscillator outputs arrive as asynchronous pins, sampled here,
// and that the processor clock register and standby logic sit outside.
//
// Function
// [RULE_01] ring stop only with option and non-ring cpu
// [RULE_02] ring stop bit: 0 runs, 1 stops
// [RULE_03] software checks status 1 before ring stop
// [RULE_04] reset clears ring, select and x1 stop
// [RULE_05] select bit: 0 ring, 1 x1
// [RULE_06] bit 1 reads actual cpu source
// [RULE_07] peripherals take ring clock while on ring
// [RULE_08] software stops peripherals before going to ring
// [RULE_09] status and select set before leaving subsystem
// [RULE_10] x1 stop bit valid only on ring
// [RULE_11] software checks status 0 before x1 stop
// [RULE_12] subsystem mode stops x1 by processor bit
// [RULE_13] settle status clears on reset, stop, x1 stop
// [RULE_14] settle bits set in thermometer order, stay
// [RULE_15] after stop, count only to selected wait
// [RULE_16] wait codes 1..5 select settle times
// [RULE_17] wait applies only leaving stop on x1
// [RULE_18] wait counts from oscillation start only
// [RULE_19] wait select written by whole bytes only
// [RULE_20] reset: ring selected, 17 cycles withheld
// [RULE_21] glitch-free switch, status follows actual source
`timescale 1ns/1ps
`default_nettype none
module mcs_clock_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_wmask,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// build option and processor clock register
	input wire logic ring_stop_allowed,
	input wire logic subsystem_clock_select,
	input wire logic processor_main_stop_bit,
	// standby sequencing
	input wire logic stop_mode,
	// oscillator pins
	input wire logic internal_ring_oscillator_in,
	input wire logic x1_osc_in,
	output logic internal_ring_oscillator_run,
	output logic x1_osc_run,
	// clock enables
	output logic cpu_clk_en,
	output logic periph_clk_en
);
	mcs_settle_if sif ();

	logic [7:0] ring_ctrl_q;
	logic [7:0] clk_sel_q;
	logic [7:0] main_stop_q;
	logic [2:0] settle_wait_q;
	logic [1:0] osc_pin;
	logic [2:0] osc_sync_q [2];
	logic [1:0] osc_lvl_q;
	logic [1:0] osc_edge;
	logic ring_edge;
	logic x1_edge;
	mcs_pkg::mcs_src_state_type src_q;
	logic on_x1;
	logic alive_q;
	logic [4:0] start_cnt_q;
	logic start_done;
	logic stop_q;
	logic stop_entry;
	logic stop_exit;
	logic wait_hold_q;
	logic ring_stop_eff;
	logic x1_stop_eff;
	logic x1_stop_eff_q;
	logic src_edge;
	logic sel_ring_ctrl;
	logic sel_clk_sel;
	logic sel_main_stop;
	logic sel_settle_wait;

	// register decode
	assign sel_ring_ctrl = reg_addr == mcs_pkg::MCS_OFF_RING_CTRL;
	assign sel_clk_sel = reg_addr == mcs_pkg::MCS_OFF_CLK_SEL;
	assign sel_main_stop = reg_addr == mcs_pkg::MCS_OFF_MAIN_STOP;
	assign sel_settle_wait = reg_addr == mcs_pkg::MCS_OFF_SETTLE_WAIT;

	// oscillator pin sampling, three stages, edge once stages 2 and 3 agree
	assign osc_pin = {x1_osc_in, internal_ring_oscillator_in};
	genvar k;
	generate
		for (k = 0; k < 2; k++) begin : g_osc
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					osc_sync_q[k] <= 3'h0;
					osc_lvl_q[k] <= 1'b0;
				end else begin
					osc_sync_q[k] <= {osc_sync_q[k][1:0], osc_pin[k]};
					if (osc_sync_q[k][1] == osc_sync_q[k][2]) begin
						osc_lvl_q[k] <= osc_sync_q[k][2];
					end
				end
			end
			assign osc_edge[k] = (osc_sync_q[k][1] == osc_sync_q[k][2]) &&
				osc_sync_q[k][2] && !osc_lvl_q[k];
		end
	endgenerate
	assign ring_edge = osc_edge[0];
	assign x1_edge = osc_edge[1];

	// ring stop bit; writes ignored when the option forbids stopping
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ring_ctrl_q <= mcs_pkg::MCS_RST_RING_CTRL; // see [RULE_04]
		end else if (reg_wr && sel_ring_ctrl && ring_stop_allowed) begin // see [RULE_01]
			ring_ctrl_q[mcs_pkg::MCS_BIT_RING_STOP] <=
				(ring_ctrl_q[mcs_pkg::MCS_BIT_RING_STOP] &
				!reg_wmask[mcs_pkg::MCS_BIT_RING_STOP]) |
				(reg_wdata[mcs_pkg::MCS_BIT_RING_STOP] &
				reg_wmask[mcs_pkg::MCS_BIT_RING_STOP]);
		end
	end

	// cpu source select bit; the status bit is never written
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			clk_sel_q <= mcs_pkg::MCS_RST_CLK_SEL; // see [RULE_04]
		end else if (reg_wr && sel_clk_sel && reg_wmask[mcs_pkg::MCS_BIT_CLK_SEL]) begin
			clk_sel_q[mcs_pkg::MCS_BIT_CLK_SEL] <= reg_wdata[mcs_pkg::MCS_BIT_CLK_SEL];
		end
	end

	// x1 stop bit only; the other bits always read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			main_stop_q <= mcs_pkg::MCS_RST_MAIN_STOP; // see [RULE_04]
		end else if (reg_wr && sel_main_stop && reg_wmask[mcs_pkg::MCS_BIT_X1_STOP]) begin
			main_stop_q[mcs_pkg::MCS_BIT_X1_STOP] <= reg_wdata[mcs_pkg::MCS_BIT_X1_STOP];
		end
	end

	// byte write only: the mask is not consulted here
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			settle_wait_q <= mcs_pkg::MCS_RST_SETTLE_WAIT; // see [RULE_16]
		end else if (reg_wr && sel_settle_wait) begin
			settle_wait_q <= reg_wdata[mcs_pkg::MCS_WAIT_CODE_W-1:0]; // see [RULE_19]
		end
	end

	// read data, registered; unmapped offsets read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				mcs_pkg::MCS_OFF_RING_CTRL: reg_rdata <= ring_ctrl_q;
				mcs_pkg::MCS_OFF_CLK_SEL: reg_rdata <= {6'h00, on_x1,
					clk_sel_q[mcs_pkg::MCS_BIT_CLK_SEL]}; // see [RULE_06]
				mcs_pkg::MCS_OFF_MAIN_STOP: reg_rdata <= main_stop_q;
				mcs_pkg::MCS_OFF_SETTLE_STAT: reg_rdata <= {3'h0, sif.status}; // see [RULE_14]
				mcs_pkg::MCS_OFF_SETTLE_WAIT: reg_rdata <= {5'h00, settle_wait_q};
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// source switch: the old source stops giving enables before the new one
	// starts, so no shortened cpu cycle appears
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			src_q <= mcs_pkg::MCS_SRC_RING; // see [RULE_20]
		end else begin
			case (src_q)
				mcs_pkg::MCS_SRC_RING: begin
					if (clk_sel_q[mcs_pkg::MCS_BIT_CLK_SEL] && x1_osc_run && ring_edge) begin
						src_q <= mcs_pkg::MCS_SRC_TO_X1; // see [RULE_21]
					end
				end
				mcs_pkg::MCS_SRC_TO_X1: begin
					if (x1_edge) begin
						src_q <= mcs_pkg::MCS_SRC_X1; // see [RULE_21]
					end
				end
				mcs_pkg::MCS_SRC_X1: begin
					if (!clk_sel_q[mcs_pkg::MCS_BIT_CLK_SEL] && internal_ring_oscillator_run && x1_edge) begin
						src_q <= mcs_pkg::MCS_SRC_TO_RING;
					end
				end
				mcs_pkg::MCS_SRC_TO_RING: begin
					if (ring_edge) begin
						src_q <= mcs_pkg::MCS_SRC_RING;
					end
				end
				default: src_q <= mcs_pkg::MCS_SRC_RING;
			endcase
		end
	end

	// status follows the source actually feeding the cpu
	assign on_x1 = (src_q == mcs_pkg::MCS_SRC_X1) ||
		(src_q == mcs_pkg::MCS_SRC_TO_RING); // see [RULE_21]

	// oscillators held stopped during reset, released one cycle after
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			alive_q <= 1'b0; // see [RULE_20]
		end else begin
			alive_q <= 1'b1;
		end
	end

	// cpu clock withheld for the first ring cycles after reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_cnt_q <= 5'h00;
		end else if (ring_edge && !start_done) begin
			start_cnt_q <= start_cnt_q + 5'h01; // see [RULE_20]
		end
	end
	assign start_done = start_cnt_q == mcs_pkg::MCS_START_RING_CYCLES;

	// the ring and x1 stop bits only act on a source the cpu is not using; the processor bit stops x1 even with the cpu on x1
	assign ring_stop_eff = ring_stop_allowed && ring_ctrl_q[mcs_pkg::MCS_BIT_RING_STOP] &&
		(on_x1 || subsystem_clock_select); // see [RULE_01]
	// on subsystem clock only the processor bit stops x1
	assign x1_stop_eff = (main_stop_q[mcs_pkg::MCS_BIT_X1_STOP] && !on_x1 &&
		!subsystem_clock_select) || processor_main_stop_bit; // see [RULE_10] see [RULE_12]

	// a ring that cannot be stopped keeps running through stop as well
	always_comb begin
		internal_ring_oscillator_run = alive_q && !ring_stop_eff &&
			!(stop_mode && ring_stop_allowed); // see [RULE_02] see [RULE_01]
		x1_osc_run = alive_q && !x1_stop_eff && !stop_mode;
	end

	// stop instruction tracking
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stop_q <= 1'b0;
			x1_stop_eff_q <= 1'b0;
		end else begin
			stop_q <= stop_mode;
			x1_stop_eff_q <= x1_stop_eff;
		end
	end
	assign stop_entry = stop_mode && !stop_q;
	assign stop_exit = !stop_mode && stop_q;

	// after stop on x1, hold the cpu until the selected wait has run
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_hold_q <= 1'b0;
		end else if (stop_exit && on_x1) begin
			wait_hold_q <= 1'b1; // see [RULE_17]
		end else if (sif.wait_done) begin
			wait_hold_q <= 1'b0;
		end
	end

	// wait limit armed by stop, dropped again when x1 is stopped
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sif.limit <= 1'b0;
		end else if (stop_entry) begin
			sif.limit <= 1'b1; // see [RULE_15]
		end else if (x1_stop_eff && !x1_stop_eff_q) begin
			sif.limit <= 1'b0;
		end
	end

	// clear stays high while x1_stop_eff holds x1 stopped, so counting restarts from zero
	assign sif.x1_edge = x1_edge;
	assign sif.clear = stop_entry || x1_stop_eff; // see [RULE_13]
	assign sif.wait_code = settle_wait_q;

	// the counter only sees synchronised x1 edges, never the raw pin
	mcs_settle_counter u_settle (
		.clk (clk),
		.nrst (nrst),
		.sif (sif)
	);

	// peripherals follow whichever source the cpu is on
	assign src_edge = (src_q == mcs_pkg::MCS_SRC_RING) ? ring_edge :
		(src_q == mcs_pkg::MCS_SRC_X1) ? x1_edge : 1'b0;

	// registered, so every enable is a clean one-cycle pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cpu_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
		end else begin
			cpu_clk_en <= src_edge && start_done && !stop_mode && !wait_hold_q; // see [RULE_05]
			periph_clk_en <= src_edge && start_done && !stop_mode; // see [RULE_07]
		end
	end
endmodule // mcs_clock_ctrl
`default_nettype wire

// ### verification/mcs_clock_ctrl_props.sv
// port checker of the clock control block.
// assumes it is bound onto mcs_clock_ctrl.
`timescale 1ns/1ps
`default_nettype none
module mcs_clock_ctrl_props (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// controls and outputs
	input wire logic ring_stop_allowed,
	input wire logic processor_main_stop_bit,
	input wire logic stop_mode,
	input wire logic internal_ring_oscillator_run,
	input wire logic x1_osc_run,
	input wire logic cpu_clk_en
);
	logic [7:0] age_q;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			age_q <= 8'h00;
		end else if (age_q != 8'hff) begin
			age_q <= age_q + 8'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence rd_at(logic [15:0] a);
		reg_rd && reg_addr == a;
	endsequence
	a_pulse_once: assert property (cpu_clk_en |=> !cpu_clk_en)
		else $error("cpu enable longer than one cycle");
	// 17 ring edges at four clocks each at the very least
	a_start_hold: assert property (age_q < 8'h44 |-> !cpu_clk_en)
		else $error("cpu enable during start hold");
	a_stop_hold: assert property (stop_mode && $past(stop_mode) |->
		!cpu_clk_en)
		else $error("cpu enable during stop");
	a_ring_guard: assert property (age_q > 8'h01 && !internal_ring_oscillator_run |->
		ring_stop_allowed)
		else $error("ring stopped against option");
	a_settle_shape: assert property (rd_at(16'hffa3) |=>
		reg_rdata inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f})
		else $error("settle status not thermometer");
	a_wait_field: assert property (rd_at(16'hffa4) |=>
		reg_rdata[7:3] == 5'h00)
		else $error("wait select high bits set");
	a_x1_kept: assert property (rd_at(16'hffa1) ##1 reg_rdata[1] |->
		x1_osc_run || processor_main_stop_bit)
		else $error("x1 stopped while cpu on x1");
	a_ring_kept: assert property (rd_at(16'hffa1) ##1 !reg_rdata[1] |->
		internal_ring_oscillator_run)
		else $error("ring stopped while cpu on ring");
	a_x1_stop_clear: assert property (age_q > 8'h01 && !x1_osc_run &&
		$past(!x1_osc_run) && reg_rd && reg_addr == 16'hffa3 |=> reg_rdata == 8'h00)
		else $error("settle status kept with x1 stopped");
endmodule // mcs_clock_ctrl_props
bind mcs_clock_ctrl mcs_clock_ctrl_props mcs_clock_ctrl_props_inst (.clk(clk), .nrst(nrst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ring_stop_allowed(ring_stop_allowed), .processor_main_stop_bit(processor_main_stop_bit),
	.stop_mode(stop_mode), .internal_ring_oscillator_run(internal_ring_oscillator_run), .x1_osc_run(x1_osc_run),
	.cpu_clk_en(cpu_clk_en));
`default_nettype wire

// ### verification/mcs_osc_model.sv
// stand-in for the ring and x1 oscillators.
// assumes run enables come from the clock control.
`timescale 1ns/1ps
`default_nettype none
module mcs_osc_model (
	// run enables
	input wire logic internal_ring_oscillator_run,
	input wire logic x1_osc_run,
	// oscillator pins
	output logic internal_ring_oscillator_in,
	output logic x1_osc_in
);
	// a stopped oscillator sits low instead of keeping a stale phase
	initial internal_ring_oscillator_in = 1'b0;
	initial x1_osc_in = 1'b0;
	always #28 internal_ring_oscillator_in = internal_ring_oscillator_run ? !internal_ring_oscillator_in : 1'b0;
	always #20 x1_osc_in = x1_osc_run ? !x1_osc_in : 1'b0;
endmodule // mcs_osc_model
`default_nettype wire

// ### verification/mcs_clock_ctrl_tb.sv
// self-checking bench of the clock control block.
// assumes the oscillator model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module mcs_clock_ctrl_tb;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_wmask = 8'hff;
	logic reg_rd = 1'b0;
	logic ring_stop_allowed = 1'b0;
	logic subsystem_clock_select = 1'b0;
	logic processor_main_stop_bit = 1'b0;
	logic stop_mode = 1'b0;
	logic [7:0] reg_rdata;
	logic internal_ring_oscillator_in, x1_osc_in, internal_ring_oscillator_run, x1_osc_run, cpu_clk_en, periph_clk_en;
	logic [15:0] row_addr [6] = '{16'hffa0, 16'hffa1, 16'hffa2, 16'hffa3, 16'hffa4, 16'hffa5};
	logic [7:0] row_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
	logic [7:0] v;
	int n_errors = 0;
	int n_compared = 0;
	int t;
	int np;
	always #4 clk = !clk;
	mcs_osc_model mcs_osc_model_inst (.internal_ring_oscillator_run(internal_ring_oscillator_run), .x1_osc_run(x1_osc_run),
		.internal_ring_oscillator_in(internal_ring_oscillator_in), .x1_osc_in(x1_osc_in));
	mcs_clock_ctrl mcs_clock_ctrl_inst (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ring_stop_allowed(ring_stop_allowed),
		.subsystem_clock_select(subsystem_clock_select),
		.processor_main_stop_bit(processor_main_stop_bit), .stop_mode(stop_mode),
		.internal_ring_oscillator_in(internal_ring_oscillator_in), .x1_osc_in(x1_osc_in), .internal_ring_oscillator_run(internal_ring_oscillator_run),
		.x1_osc_run(x1_osc_run), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h want %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
		reg_addr = a;
		reg_wdata = d;
		reg_wmask = m;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
		step(1);
	endtask
	task automatic rd(input logic [15:0] a);
		reg_addr = a;
		reg_rd = 1'b1;
		step(1);
		reg_rd = 1'b0;
		v = reg_rdata;
		step(1);
	endtask
	task automatic poll(input logic [15:0] a, input logic [7:0] e, input int tries);
		rd(a);
		for (int i = 0; i < tries && v !== e; i++) begin
			step(20);
			rd(a);
		end
		chk(v, e);
	endtask
	// counts clocks to the next cpu enable, and peripheral enables meanwhile
	task automatic wait_cpu(input int lim);
		t = 0;
		np = 0;
		while (cpu_clk_en !== 1'b1 && t < lim) begin
			np += (periph_clk_en === 1'b1);
			step(1);
			t++;
		end
	endtask
	task automatic summarize();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		step(60000);
		n_errors++;
		summarize();
	end
	initial begin
		step(20);
		nrst = 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(row_addr[i]);
			chk(v, row_exp[i]);
		end
		wait_cpu(400);
		chk({7'h00, t > 80 && cpu_clk_en === 1'b1}, 8'h01);
		wr(16'hffa4, 8'h01, 8'hff);
		rd(16'hffa4);
		chk(v, 8'h01);
		ring_stop_allowed = 1'b1;
		wr(16'hffa0, 8'h01, 8'hff);
		chk({7'h00, internal_ring_oscillator_run}, 8'h01);
		wr(16'hffa0, 8'h00, 8'hff);
		poll(16'hffa3, 8'h10, 700);
		chk({7'h00, $time > 81000}, 8'h01);
		wr(16'hffa1, 8'h01, 8'h01);
		poll(16'hffa1, 8'h03, 20);
		wr(16'hffa0, 8'h01, 8'h01);
		chk({7'h00, internal_ring_oscillator_run}, 8'h00);
		wr(16'hffa0, 8'h00, 8'hff);
		chk({7'h00, internal_ring_oscillator_run}, 8'h01);
		wr(16'hffa2, 8'h80, 8'h80);
		chk({7'h00, x1_osc_run}, 8'h01);
		wr(16'hffa2, 8'h00, 8'hff);
		ring_stop_allowed = 1'b0;
		wr(16'hffa0, 8'h01, 8'hff);
		rd(16'hffa0);
		chk(v, 8'h00);
		chk({7'h00, internal_ring_oscillator_run}, 8'h01);
		stop_mode = 1'b1;
		step(30);
		rd(16'hffa3);
		chk(v, 8'h00);
		chk({7'h00, internal_ring_oscillator_run}, 8'h01);
		stop_mode = 1'b0;
		wait_cpu(12000);
		chk({7'h00, t > 10000 && cpu_clk_en === 1'b1}, 8'h01);
		chk({7'h00, np > 0}, 8'h01);
		rd(16'hffa3);
		chk(v, 8'h10);
		subsystem_clock_select = 1'b1;
		processor_main_stop_bit = 1'b1;
		step(2);
		chk({7'h00, x1_osc_run}, 8'h00);
		processor_main_stop_bit = 1'b0;
		step(2);
		subsystem_clock_select = 1'b0;
		wr(16'hffa1, 8'h00, 8'h01);
		poll(16'hffa1, 8'h00, 20);
		wr(16'hffa2, 8'h80, 8'h80);
		chk({7'h00, x1_osc_run}, 8'h00);
		rd(16'hffa3);
		chk(v, 8'h00);
		wr(16'hffa2, 8'h00, 8'hff);
		wait_cpu(100);
		chk({7'h00, cpu_clk_en}, 8'h01);
		nrst = 1'b0;
		step(3);
		nrst = 1'b1;
		rd(16'hffa1);
		chk(v, 8'h00);
		rd(16'hffa4);
		chk(v, 8'h05);
		summarize();
	end
endmodule // mcs_clock_ctrl_tb
`default_nettype wire
